// >>> rtl/out_term_pkg.sv
package out_term_pkg;
    localparam logic [5:0]  IDX_UNLOCK_KEY     = 6'h1f;
    localparam logic [5:0]  IDX_FEATURES       = 6'h20;
    localparam logic [5:0]  IDX_USER_OFFSET    = 6'h21;
    localparam logic [5:0]  IDX_USER_GAIN      = 6'h22;
    localparam logic [5:0]  IDX_USER_POWER_UP  = 6'h23;
    localparam logic [15:0] RST_FEATURES       = 16'h0002;
    localparam logic [15:0] RST_USER_OFFSET    = 16'h0000;
    localparam logic [15:0] RST_USER_GAIN      = 16'h0100;
    localparam logic [15:0] RST_USER_POWER_UP  = 16'h0000;
    localparam logic [15:0] KEY_PARAM_UNLOCK   = 16'h1235;
    localparam logic [15:0] KEY_CALIBRATE      = 16'haffe;
    localparam logic [15:0] FULL_SCALE         = 16'h7fff;
    localparam int          FEAT_USER_SCALE    = 0;
    localparam int          FEAT_MAKER_SCALE   = 1;
    localparam int          FEAT_WDOG_OFF      = 2;
    localparam int          FEAT_USER_POWER_UP = 8;
    localparam int          CTL_REG_MODE       = 7;
    localparam int          CTL_WRITE          = 6;
    localparam int          CTL_COMP_EN        = 6;
    localparam int          CTL_GAIN_CAL       = 4;
    localparam int          CTL_OFFSET_CAL     = 3;
    localparam int          CTL_FAST_STEP      = 2;
    localparam int          CTL_STEP_UP        = 1;
    localparam int          CTL_STEP_DOWN      = 0;
    localparam int          CLK_MHZ            = 250;
    localparam int          WDOG_MS            = 100;
    localparam int          SLOW_STEP_MS       = 1000;
    localparam int          FAST_STEP_MS       = 50;
    localparam int          WDOG_CYCLES        = WDOG_MS * CLK_MHZ * 1000;
    localparam int          SLOW_STEP_CYCLES   = SLOW_STEP_MS * CLK_MHZ * 1000;
    localparam int          FAST_STEP_CYCLES   = FAST_STEP_MS * CLK_MHZ * 1000;

    // One channel frame from the coupler
    typedef struct packed {
        logic [7:0]  control;
        logic [15:0] value;
    } frame_out_type;

    // One channel frame back to the coupler
    typedef struct packed {
        logic [7:0]  status;
        logic [15:0] value;
    } frame_in_type;

    // Calibration sequencer state
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_SAVE = 2'b11
    } cal_state_type;
endpackage

// >>> rtl/output_terminal_register_access.sv
// Contract
// - Value 0..32767 spans full output range
// - Full 16-bit resolution only without maker scaling
// - User line applied only when feature bit 0
// - Maker line applied while feature bit 1
// - Feature bit 2 clear runs watchdog
// - Overflow after 100 ms without process data
// - Feature bit 8 selects user switch-on value
// - User switch-on value loaded at reset, overflow
// - User gain is 8.8 signed, reset 0x0100
// - Control bit 7 selects register mode
// - Bit 6 clear reads, set writes
// - Register index from control bits 0..5
// - Status byte first, then 16-bit value
// - Optional pad byte for word alignment
// - Read status echoes control byte
// - Write status is control with bit 6 cleared
// - Calibration only while key 0xAFFE held
// - Commit calibration when key leaves 0xAFFE
// - Process control: compensate, gain, offset, up, down
// - Step interval 1000 ms slow, 50 ms fast
// - Process-mode status carries no information
// - Protected writes only while key 0x1235 held
// - Key reads back only while unlocked
`timescale 1ns/10ps
`default_nettype none
module output_terminal_register_access #(
    parameter int WDOG_COUNT = out_term_pkg::WDOG_CYCLES,
    parameter int SLOW_COUNT = out_term_pkg::SLOW_STEP_CYCLES,
    parameter int FAST_COUNT = out_term_pkg::FAST_STEP_CYCLES
) (
    input  wire logic                        clk_sys,     // System clock
    input  wire logic                        rst_n,       // Synchronous reset
    input  wire logic                        frameValid,  // New frame strobe
    input  wire out_term_pkg::frame_out_type frameOut,    // Control and value
    input  wire logic                        wordAlign,   // Pad byte layout strap
    output var  out_term_pkg::frame_in_type  frameIn,     // Status and value
    output var  logic                        frameDone,   // Answer strobe
    output var  logic [31:0]                 imageIn,     // Serialised answer
    output var  logic [15:0]                 outputLevel, // Value to scaling path
    output var  logic                        useUserLine, // User line on
    output var  logic                        useMakerLine,// Maker line on
    output var  logic                        wdogTripped, // Overflow pulse
    output var  logic                        calEnable,   // Compensation on
    output var  logic                        calGainUp,   // Gain step up pulse
    output var  logic                        calGainDown, // Gain step down pulse
    output var  logic                        calOffsUp,   // Offset step up pulse
    output var  logic                        calOffsDown, // Offset step down pulse
    output var  logic                        calCommit    // Store to nonvolatile
);
    import out_term_pkg::*;

    logic [15:0]   unlockKey, next_unlockKey;
    logic [15:0]   operatingFeatures, next_operatingFeatures;
    logic [15:0]   userLineOffset, next_userLineOffset;
    logic [15:0]   userLineGain, next_userLineGain;
    logic [15:0]   userPowerUpLevel, next_userPowerUpLevel;
    frame_in_type  next_frameIn;
    logic          next_frameDone;
    logic [31:0]   next_imageIn;
    logic [15:0]   next_outputLevel;
    logic [31:0]   wdogCount, next_wdogCount;
    logic          next_wdogTripped;
    cal_state_type calState, next_calState;
    logic [31:0]   stepCount, next_stepCount;
    logic [4:0]    next_calPulses;
    logic [7:0]    procControl, next_procControl;
    logic          next_calCommit;
    logic          syncValidA, syncValidB;
    frame_out_type syncFrameA, syncFrameB;
    logic          syncAlignA, syncAlignB;
    logic          validSeen;
    logic          regMode, isWrite, unlocked;
    logic [5:0]    regIndex;

    // Read decode of the register file
    function automatic logic [15:0] readReg(input logic [5:0] idx);
        case (idx)
            IDX_UNLOCK_KEY:    readReg = (unlockKey == KEY_PARAM_UNLOCK) ? unlockKey : 16'h0000;
            IDX_FEATURES:      readReg = operatingFeatures;
            IDX_USER_OFFSET:   readReg = userLineOffset;
            IDX_USER_GAIN:     readReg = userLineGain;
            IDX_USER_POWER_UP: readReg = userPowerUpLevel;
            default:           readReg = 16'h0000;
        endcase
    endfunction

    // Pin inputs pass two flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            syncValidA <= 1'b0;
            syncValidB <= 1'b0;
            syncFrameA <= '0;
            syncFrameB <= '0;
            syncAlignA <= 1'b0;
            syncAlignB <= 1'b0;
            validSeen  <= 1'b0;
        end else begin
            syncValidA <= frameValid;
            syncValidB <= syncValidA;
            syncFrameA <= frameOut;
            syncFrameB <= syncFrameA;
            syncAlignA <= wordAlign;
            syncAlignB <= syncAlignA;
            validSeen  <= syncValidB;
        end
    end

    // Frame fields
    assign regMode  = syncFrameB.control[CTL_REG_MODE];
    assign isWrite  = syncFrameB.control[CTL_WRITE];
    assign regIndex = syncFrameB.control[5:0];
    assign unlocked = (unlockKey == KEY_PARAM_UNLOCK);

    // Register access and answer
    always_comb begin
        logic newFrame;
        newFrame               = syncValidB && !validSeen;
        next_unlockKey         = unlockKey;
        next_operatingFeatures = operatingFeatures;
        next_userLineOffset    = userLineOffset;
        next_userLineGain      = userLineGain;
        next_userPowerUpLevel  = userPowerUpLevel;
        next_frameIn           = frameIn;
        next_frameDone         = 1'b0;
        next_imageIn           = imageIn;
        if (newFrame) begin
            next_frameDone = 1'b1;
            if (regMode && !isWrite) begin
                next_frameIn = '{status: syncFrameB.control,
                                 value: readReg(regIndex)};
            end else if (regMode) begin
                next_frameIn = '{status: {2'b10, regIndex}, value: 16'h0000};
                if (regIndex == IDX_UNLOCK_KEY) begin
                    next_unlockKey = syncFrameB.value;
                end else if (unlocked) begin
                    case (regIndex)
                        IDX_FEATURES:      next_operatingFeatures = syncFrameB.value;
                        IDX_USER_OFFSET:   next_userLineOffset    = syncFrameB.value;
                        IDX_USER_GAIN:     next_userLineGain      = syncFrameB.value;
                        IDX_USER_POWER_UP: next_userPowerUpLevel  = syncFrameB.value;
                        default:           next_operatingFeatures = operatingFeatures;
                    endcase
                end
            end else begin
                next_frameIn = '{status: 8'h00, value: 16'h0000};
            end
            // Status first, optional pad byte next, then value
            if (syncAlignB) begin
                next_imageIn = {next_frameIn.value, 8'h00, next_frameIn.status};
            end else begin
                next_imageIn = {8'h00, next_frameIn.value, next_frameIn.status};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            unlockKey         <= 16'h0000;
            operatingFeatures <= RST_FEATURES;
            userLineOffset    <= RST_USER_OFFSET;
            userLineGain      <= RST_USER_GAIN;
            userPowerUpLevel  <= RST_USER_POWER_UP;
            frameIn           <= '0;
            frameDone         <= 1'b0;
            imageIn           <= 32'h0000_0000;
        end else begin
            unlockKey         <= next_unlockKey;
            operatingFeatures <= next_operatingFeatures;
            userLineOffset    <= next_userLineOffset;
            userLineGain      <= next_userLineGain;
            userPowerUpLevel  <= next_userPowerUpLevel;
            frameIn           <= next_frameIn;
            frameDone         <= next_frameDone;
            imageIn           <= next_imageIn;
        end
    end

    // Output value, watchdog and scaling selects
    always_comb begin
        logic procFrame;
        logic [15:0] powerUp;
        procFrame = syncValidB && !validSeen && !regMode;
        powerUp = operatingFeatures[FEAT_USER_POWER_UP] ? userPowerUpLevel
                                                        : 16'h0000;
        next_wdogCount   = wdogCount;
        next_wdogTripped = 1'b0;
        next_outputLevel = outputLevel;
        if (procFrame) begin
            next_outputLevel = syncFrameB.value;
        end
        if (operatingFeatures[FEAT_WDOG_OFF] || procFrame) begin
            next_wdogCount = 32'h0000_0000;
        end else if (wdogCount >= 32'(WDOG_COUNT - 1)) begin
            next_wdogCount   = 32'h0000_0000;
            next_wdogTripped = 1'b1;
            next_outputLevel = powerUp;
        end else begin
            next_wdogCount = wdogCount + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wdogCount    <= 32'h0000_0000;
            wdogTripped  <= 1'b0;
            outputLevel  <= RST_USER_POWER_UP;
            useUserLine  <= 1'b0;
            useMakerLine <= 1'b1;
        end else begin
            wdogCount    <= next_wdogCount;
            wdogTripped  <= next_wdogTripped;
            outputLevel  <= next_outputLevel;
            useUserLine  <= operatingFeatures[FEAT_USER_SCALE];
            useMakerLine <= operatingFeatures[FEAT_MAKER_SCALE];
        end
    end

    // Calibration sequencer, run from the last process control byte
    always_comb begin
        logic [7:0] ctl;
        logic armed;
        logic [31:0] period;
        ctl    = procControl;  // Live lines go stale once a frame is released
        next_procControl = (syncValidB && !validSeen && !regMode) ? syncFrameB.control
                                                                   : procControl;
        armed  = (unlockKey == KEY_CALIBRATE);
        period = ctl[CTL_FAST_STEP] ? 32'(FAST_COUNT) : 32'(SLOW_COUNT);
        next_calState  = calState;
        next_stepCount = stepCount;
        next_calPulses = 5'b00000;
        next_calCommit = 1'b0;
        next_calPulses[4] = armed && ctl[CTL_COMP_EN];
        case (calState)
            CAL_IDLE: begin
                next_stepCount = 32'h0000_0000;
                if (armed) begin
                    next_calState = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (!armed) begin
                    next_calState = CAL_SAVE;
                end else if (!(ctl[CTL_STEP_UP] ^ ctl[CTL_STEP_DOWN])) begin
                    next_stepCount = 32'h0000_0000;
                end else if (stepCount >= period - 32'h0000_0001) begin
                    next_stepCount = 32'h0000_0000;
                    next_calPulses[3] = ctl[CTL_GAIN_CAL] && ctl[CTL_STEP_UP];
                    next_calPulses[2] = ctl[CTL_GAIN_CAL] && ctl[CTL_STEP_DOWN];
                    next_calPulses[1] = ctl[CTL_OFFSET_CAL] && ctl[CTL_STEP_UP];
                    next_calPulses[0] = ctl[CTL_OFFSET_CAL] && ctl[CTL_STEP_DOWN];
                end else begin
                    next_stepCount = stepCount + 32'h0000_0001;
                end
            end
            CAL_SAVE: begin
                next_calCommit = 1'b1;
                next_calState  = CAL_IDLE;
            end
            default: next_calState = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            calState    <= CAL_IDLE;
            procControl <= 8'h00;
            stepCount   <= 32'h0000_0000;
            calEnable   <= 1'b0;
            calGainUp   <= 1'b0;
            calGainDown <= 1'b0;
            calOffsUp   <= 1'b0;
            calOffsDown <= 1'b0;
            calCommit   <= 1'b0;
        end else begin
            calState    <= next_calState;
            procControl <= next_procControl;
            stepCount   <= next_stepCount;
            calEnable   <= next_calPulses[4];
            calGainUp   <= next_calPulses[3];
            calGainDown <= next_calPulses[2];
            calOffsUp   <= next_calPulses[1];
            calOffsDown <= next_calPulses[0];
            calCommit   <= next_calCommit;
        end
    end

    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Register answers, write protection and scaling selects
    a_read_echo: assert property (syncValidB && !validSeen && regMode && !isWrite
        |=> frameDone && frameIn.status == $past(syncFrameB.control))
        else $error("read status not echoed");
    a_write_ack: assert property (syncValidB && !validSeen && regMode && isWrite
        |=> frameIn.status == {2'b10, $past(regIndex)})
        else $error("write acknowledge wrong");
    a_write_lock: assert property (syncValidB && !validSeen && regMode && isWrite
        && !unlocked && regIndex != IDX_UNLOCK_KEY
        |=> $stable(operatingFeatures) && $stable(userLineOffset)
        && $stable(userLineGain) && $stable(userPowerUpLevel))
        else $error("locked register written");
    a_key_hidden: assert property (syncValidB && !validSeen && regMode && !isWrite
        && regIndex == IDX_UNLOCK_KEY && !unlocked |=> frameIn.value == 16'h0000)
        else $error("key visible while locked");
    a_proc_status: assert property (syncValidB && !validSeen && !regMode
        |=> frameIn.status == 8'h00)
        else $error("process status not zero");
    a_scale_select: assert property (
        useUserLine == $past(operatingFeatures[FEAT_USER_SCALE])
        && useMakerLine == $past(operatingFeatures[FEAT_MAKER_SCALE]))
        else $error("scaling select lags");

    // Watchdog
    a_wdog_fire: assert property (wdogTripped |-> outputLevel ==
        ($past(operatingFeatures[FEAT_USER_POWER_UP]) ? $past(userPowerUpLevel) : 16'h0000))
        else $error("wrong switch-on value");
    a_wdog_off: assert property (operatingFeatures[FEAT_WDOG_OFF] |=> !wdogTripped)
        else $error("watchdog fired while off");
    a_wdog_kick: assert property (syncValidB && !validSeen && !regMode
        |=> wdogCount == 0)
        else $error("watchdog not restarted");

    // Calibration
    a_cal_commit: assert property (calState == CAL_RUN && unlockKey != KEY_CALIBRATE
        |=> ##1 calCommit)
        else $error("calibration not committed");
    a_cal_guard: assert property (calGainUp || calOffsUp |-> calState == CAL_RUN)
        else $error("step outside calibration");
    a_proc_latch: assert property (syncValidB && !validSeen && !regMode
        |=> procControl == $past(syncFrameB.control))
        else $error("process control not kept");
    a_cal_enable: assert property (calEnable |-> $past(unlockKey) == KEY_CALIBRATE)
        else $error("compensation on without key");
    a_step_bound: assert property (stepCount < 32'(SLOW_COUNT))
        else $error("step counter overran");

    // Main scenarios
    c_reg_read:  cover property (frameDone && frameIn.status[7:6] == 2'b10);
    c_wdog_trip: cover property (wdogTripped);
    c_cal_step:  cover property (calGainUp);
    c_offs_step: cover property (calOffsDown);
    c_commit:    cover property (calCommit);
endmodule // output_terminal_register_access
`default_nettype wire

// >>> verification/coupler_model.sv
`timescale 1ns/10ps
`default_nettype none
module coupler_model (
    input  wire logic                        clk_sys,    // System clock
    input  wire logic                        frameDone,  // Answer strobe
    input  wire out_term_pkg::frame_in_type  frameIn,    // Answer frame
    input  wire logic [31:0]                 imageIn,    // Serialised answer
    output var  logic                        frameValid, // Frame strobe
    output var  out_term_pkg::frame_out_type frameOut,   // Control and value
    output var  int                          nLost       // Unanswered frames
);
    import out_term_pkg::*;

    // Idle bus at time zero
    initial begin
        frameValid = 1'b0;
        frameOut   = '0;
        nLost      = 0;
    end

    // One frame out, held until answered, then released with a gap
    task automatic exchange(input logic [7:0] ctl, input logic [15:0] val,
                            output frame_in_type ans, output logic [31:0] img);
        int n;
        n = 0;
        @(negedge clk_sys);
        frameOut   <= {ctl, val};
        frameValid <= 1'b1;
        do begin
            @(negedge clk_sys);
            n++;
        end while (frameDone !== 1'b1 && n < 20);
        if (frameDone !== 1'b1) nLost++;
        ans = frameIn;
        img = imageIn;
        frameValid <= 1'b0;
        frameOut   <= ~frameOut; // Stale data is not left on the lines
        repeat (3) @(negedge clk_sys);
    endtask
endmodule // coupler_model
`default_nettype wire

// >>> verification/output_terminal_register_access_test.sv
`timescale 1ns/10ps
`default_nettype none
module output_terminal_register_access_test;
    import out_term_pkg::*;
    localparam int WDOG = 50;
    localparam int SLOW = 40;
    localparam int FAST = 8;
    logic          clk_sys, rst_n, wordAlign, frameValid, frameDone;
    frame_out_type frameOut;
    frame_in_type  frameIn, ans;
    logic [31:0]   imageIn, img;
    logic [15:0]   outputLevel;
    logic          useUserLine, useMakerLine, wdogTripped, calEnable;
    logic          calGainUp, calGainDown, calOffsUp, calOffsDown, calCommit;
    int            nLost, t, n;
    int            failures = 0;
    int            n_compared = 0;
    int            nTrip = 0;
    int            nGainUp = 0;
    int            nOffsDown = 0;
    int            nGainDown = 0;
    int            nOffsUp = 0;
    int            nCommit = 0;
    logic [5:0]    wIdx[4] = '{6'h21, 6'h22, 6'h23, 6'h20};
    logic [15:0]   wVal[4] = '{16'h1234, 16'hff80, 16'h4567, 16'h0101};

    output_terminal_register_access #(
        .WDOG_COUNT(WDOG), .SLOW_COUNT(SLOW), .FAST_COUNT(FAST)
    ) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .frameValid(frameValid),
        .frameOut(frameOut), .wordAlign(wordAlign), .frameIn(frameIn),
        .frameDone(frameDone), .imageIn(imageIn), .outputLevel(outputLevel),
        .useUserLine(useUserLine), .useMakerLine(useMakerLine),
        .wdogTripped(wdogTripped), .calEnable(calEnable), .calGainUp(calGainUp),
        .calGainDown(calGainDown), .calOffsUp(calOffsUp),
        .calOffsDown(calOffsDown), .calCommit(calCommit)
    );

    coupler_model partner (
        .clk_sys(clk_sys), .frameDone(frameDone), .frameIn(frameIn),
        .imageIn(imageIn), .frameValid(frameValid), .frameOut(frameOut),
        .nLost(nLost)
    );

    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Pulse counters, one count per pulse
    always @(posedge clk_sys) begin
        if (wdogTripped === 1'b1) nTrip <= nTrip + 1;
        if (calGainUp === 1'b1) nGainUp <= nGainUp + 1;
        if (calOffsDown === 1'b1) nOffsDown <= nOffsDown + 1;
        if (calGainDown === 1'b1) nGainDown <= nGainDown + 1;
        if (calOffsUp === 1'b1) nOffsUp <= nOffsUp + 1;
        if (calCommit === 1'b1) nCommit <= nCommit + 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic regRead(input logic [5:0] idx, output logic [15:0] val);
        partner.exchange({2'b10, idx}, 16'h0000, ans, img);
        check("readStatus", {24'h0, ans.status}, {24'h0, 2'b10, idx});
        val = ans.value;
    endtask

    task automatic regWrite(input logic [5:0] idx, input logic [15:0] val);
        partner.exchange({2'b11, idx}, val, ans, img);
        check("writeAck", {24'h0, ans.status}, {24'h0, 2'b10, idx});
    endtask

    task automatic expectReg(input logic [5:0] idx, input logic [15:0] exp);
        logic [15:0] v;
        regRead(idx, v);
        check("regValue", {16'h0, v}, {16'h0, exp});
    endtask

    task automatic procFrame(input logic [7:0] ctl, input logic [15:0] val);
        partner.exchange(ctl, val, ans, img);
        check("procStatus", {24'h0, ans.status}, 32'h0);
        check("outputLevel", {16'h0, outputLevel}, {16'h0, val});
    endtask

    // Cycles from the last process frame to the overflow pulse
    task automatic waitTrip(input logic [15:0] lvl);
        int k;
        k = 3;
        while (wdogTripped !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        check("wdogDelay", 32'(k >= WDOG - 4 && k <= WDOG + 4), 32'h1);
        @(negedge clk_sys);
        check("switchOnLevel", {16'h0, outputLevel}, {16'h0, lvl});
    endtask

    task automatic finish_test();
        failures += nLost;
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n     = 1'b0;
        wordAlign = 1'b0;
        repeat (5) @(negedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check("userLine", {31'h0, useUserLine}, 32'h0);
        check("makerLine", {31'h0, useMakerLine}, 32'h1);
        expectReg(6'h20, 16'h0002);
        expectReg(6'h21, 16'h0000);
        expectReg(6'h22, 16'h0100);
        expectReg(6'h23, 16'h0000);
        expectReg(6'h1f, 16'h0000);
        regWrite(6'h22, 16'h0080);
        expectReg(6'h22, 16'h0100);
        regWrite(6'h1f, 16'h1235);
        for (int a = 0; a < 2; a++) begin
            wordAlign <= a[0];
            expectReg(6'h1f, 16'h1235);
            check("image", img, (a != 0) ? 32'h1235009f : 32'h0012359f);
        end
        foreach (wIdx[i]) regWrite(wIdx[i], wVal[i]);
        foreach (wIdx[i]) expectReg(wIdx[i], wVal[i]);
        check("userLine", {31'h0, useUserLine}, 32'h1);
        check("makerLine", {31'h0, useMakerLine}, 32'h0);
        regWrite(6'h3f, 16'hbeef);
        expectReg(6'h3f, 16'h0000);
        procFrame(8'h00, 16'h7fff);
        regWrite(6'h21, 16'h1234);
        check("regModeLevel", {16'h0, outputLevel}, 32'h7fff);
        // Feed the watchdog, the last frame just before the trip wait
        t = nTrip;
        repeat (4) begin
            repeat (30) @(negedge clk_sys);
            procFrame(8'h00, 16'h1000);
        end
        check("tripsWhileFed", 32'(nTrip - t), 32'h0);
        waitTrip(16'h4567);
        regWrite(6'h20, 16'h0001);
        procFrame(8'h00, 16'h2222);
        waitTrip(16'h0000);
        regWrite(6'h20, 16'h0005);
        procFrame(8'h00, 16'h3333);
        t = nTrip;
        repeat (2 * WDOG) @(negedge clk_sys);
        check("tripsWhenOff", 32'(nTrip - t), 32'h0);
        check("heldLevel", {16'h0, outputLevel}, 32'h3333);
        // Calibration: gain fast up, then offset slow down
        regWrite(6'h1f, 16'haffe);
        expectReg(6'h1f, 16'h0000);
        procFrame(8'h56, 16'h0000);
        check("calEnable", {31'h0, calEnable}, 32'h1);
        t = nGainUp;
        repeat (10 * FAST) @(negedge clk_sys);
        check("fastSteps", 32'(nGainUp - t >= 9 && nGainUp - t <= 11), 32'h1);
        procFrame(8'h49, 16'h0000);
        t = nOffsDown;
        n = nGainUp;
        repeat (4 * SLOW) @(negedge clk_sys);
        check("slowSteps", 32'(nOffsDown - t >= 3 && nOffsDown - t <= 5), 32'h1);
        check("gainIdle", 32'(nGainUp - n), 32'h0);
        check("crossSteps", 32'(nGainDown + nOffsUp), 32'h0);
        t = nCommit;
        regWrite(6'h1f, 16'h0000);
        repeat (4) @(negedge clk_sys);
        check("commit", 32'(nCommit - t), 32'h1);
        procFrame(8'h56, 16'h0000);
        check("calLocked", {31'h0, calEnable}, 32'h0);
        t = nGainUp;
        repeat (5 * FAST) @(negedge clk_sys);
        check("lockedSteps", 32'(nGainUp - t), 32'h0);
        finish_test();
    end

    // Hang guard, well past the expected run length
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        finish_test();
    end
endmodule // output_terminal_register_access_test
`default_nettype wire
